// >>> rtl/psm_ctrl.sv
`timescale 1ns/100ps
module psm_ctrl import psm_pkg::*; #(
	parameter int unsigned SEC_CYCLES = CLK_HZ,
	parameter int unsigned LOS_CYCLES = LOS_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// Register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	// Reference pulse and phase detector results
	input  wire logic        REF_PPS,
	input  wire logic [15:0] PHASE_ERR,
	input  wire logic [15:0] FREQ_P2P,
	// Loop state
	output logic      [2:0]  LOOP_MODE,
	output logic      [7:0]  BW_INDEX,
	output logic             HOLDOVER,
	output logic             EVENT_INTERRUPT_PIN,
	// Calibration and alignment
	output logic      [15:0] PD_CAL,
	output logic      [31:0] MCLK_TRIM,
	output logic             ALIGN_X,
	output logic             ALIGN_Y,
	output logic      [15:0] BUILDOUT_PS,
	// Generated outputs
	output logic             PPS_OUT,
	output logic             OUT11
);
	logic        ref_s1_q, ref_s2_q, ref_s3_q, pulse_ev;
	logic        started_q, kick, wr_loop;
	logic [7:0]  rtctl_q, cfg_q, rate_q, tgt_q, fast_q, bkt_sz_q;
	logic [47:0] afreq_q;
	logic [11:0] pwid_q;
	logic [15:0] o11s_q, o11p_q, lolt_q, reent_q, soak_sz_q, ftol_q, pdcal_q;
	logic [31:0] trim_q;
	logic [7:0]  fast_eff, tgt_eff, bw_q, bucket_q;
	logic [15:0] prev_err_q, soak_q;
	logic [31:0] gap_q, sec_q, sec_d, wcyc;
	logic        absent, force_ho, grow, shrink, bucket_on, ovf, zero, drop, soak_ok;
	logic        align_valid, locked_once_q;
	psm_mode_e   mode_q, mode_d, prior_q;
	logic [15:0] intr_q, intr_d, intr_clr;
	logic [7:0]  rd_val;
	psm_o11_cfg_s o11_cfg;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
			input logic [7:0] n);
		return (a >= base) && (a < base + n);
	endfunction

	function automatic logic [7:0] rbyte(input logic [47:0] v, input logic [2:0] i);
		return v[8*i +: 8];
	endfunction

	function automatic logic [7:0] bw_step(input logic [7:0] diff, input logic [1:0] spd);
		logic [2:0] sh;
		logic [7:0] st;
		case (spd)
			2'h1: sh = SH_SLOWER;
			2'h2: sh = SH_SLOWEST;
			2'h3: sh = SH_FASTER;
			default: sh = SH_NORMAL;
		endcase
		st = diff >> sh;
		return (st == 8'h00) ? 8'h01 : st;
	endfunction

	// Pin passes two flops before the edge detector
	always_ff @(posedge MCLK) begin
		ref_s1_q <= REF_PPS;
		ref_s2_q <= ref_s1_q;
		ref_s3_q <= ref_s2_q;
	end
	assign pulse_ev = ref_s2_q && !ref_s3_q;

	assign kick    = WR && ADDR == A_START && WDATA[START_BIT] && !started_q;
	assign wr_loop = WR && !started_q;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			started_q <= 1'b0;
		end else if (kick) begin
			started_q <= 1'b1;
		end
	end

	// Run-time registers stay writable while the loop runs
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rtctl_q <= RT_RST;
			afreq_q <= '0;
			tgt_q   <= TGT_RST;
			lolt_q  <= LOLT_RST;
			reent_q <= REENT_RST;
			pdcal_q <= '0;
			trim_q  <= '0;
			pwid_q  <= PWID_RST;
			o11s_q  <= O11S_RST;
			o11p_q  <= O11P_RST;
		end else if (WR) begin
			if (ADDR == A_RTCTL) rtctl_q <= WDATA;
			if (hit(ADDR, A_AFREQ, 8'h06)) afreq_q[8*3'(ADDR - A_AFREQ) +: 8] <= WDATA;
			if (ADDR == A_TGT) tgt_q <= WDATA;
			if (hit(ADDR, A_LOLT, 8'h02)) lolt_q[8*1'(ADDR - A_LOLT) +: 8] <= WDATA;
			if (hit(ADDR, A_REENT, 8'h02)) reent_q[8*1'(ADDR - A_REENT) +: 8] <= WDATA;
			if (hit(ADDR, A_PDCAL, 8'h02)) pdcal_q[8*1'(ADDR - A_PDCAL) +: 8] <= WDATA;
			if (hit(ADDR, A_TRIM, 8'h04)) trim_q[8*2'(ADDR - A_TRIM) +: 8] <= WDATA;
			if (hit(ADDR, A_PWID, 8'h02)) begin
				// Upper byte carries only the four top width bits
				if (ADDR == A_PWID) pwid_q[7:0] <= WDATA;
				else pwid_q[11:8] <= WDATA[3:0];
			end
			if (hit(ADDR, A_O11S, 8'h02)) o11s_q[8*1'(ADDR - A_O11S) +: 8] <= WDATA;
			if (hit(ADDR, A_O11P, 8'h02)) o11p_q[8*1'(ADDR - A_O11P) +: 8] <= WDATA;
		end
	end

	// Loop set-up registers freeze at kickoff
	always_ff @(posedge MCLK) begin
		if (RST) begin
			cfg_q     <= CFG_RST;
			rate_q    <= RATE_RST;
			fast_q    <= FAST_RST;
			bkt_sz_q  <= BKT_RST;
			soak_sz_q <= SOAK_RST;
			ftol_q    <= FTOL_RST;
		end else if (wr_loop) begin
			if (ADDR == A_CFG) cfg_q <= {4'h0, WDATA[3:0]};
			if (ADDR == A_RATE) rate_q <= WDATA;
			if (ADDR == A_FAST) fast_q <= WDATA;
			if (ADDR == A_BKT) bkt_sz_q <= WDATA;
			if (hit(ADDR, A_SOAK, 8'h02)) soak_sz_q[8*1'(ADDR - A_SOAK) +: 8] <= WDATA;
			if (hit(ADDR, A_FTOL, 8'h02)) ftol_q[8*1'(ADDR - A_FTOL) +: 8] <= WDATA;
		end
	end

	assign fast_eff = (fast_q > FAST_BW_MAX) ? FAST_BW_MAX : fast_q;
	assign tgt_eff  = (tgt_q > fast_eff) ? fast_eff : tgt_q;
	assign align_valid = afreq_q[AF_BITS-1:0] != '0 && afreq_q[47:AF_BITS] == '0
		&& rate_q != 8'h00;

	// Presence is a plain gap counter; glitches count as pulses
	always_ff @(posedge MCLK) begin
		if (RST || pulse_ev) begin
			gap_q <= '0;
		end else if (gap_q < LOS_CYCLES) begin
			gap_q <= gap_q + 32'h1;
		end
	end
	assign absent   = !pulse_ev && gap_q >= LOS_CYCLES;
	assign force_ho = rtctl_q[FORCE_BIT];

	// Leaking bucket, shared by promotion and lock loss
	assign grow      = PHASE_ERR > prev_err_q;
	assign shrink    = PHASE_ERR < prev_err_q;
	assign bucket_on = mode_q == M_FAST || mode_q == M_LOCKING || mode_q == M_LOCKED;
	assign ovf  = bucket_on && pulse_ev && grow && bucket_q >= bkt_sz_q;
	assign zero = bucket_on && pulse_ev && shrink && bucket_q <= 8'h01;
	assign drop = ovf || (bucket_on && pulse_ev && PHASE_ERR > lolt_q);

	always_ff @(posedge MCLK) begin
		if (RST) begin
			prev_err_q <= '0;
		end else if (pulse_ev) begin
			prev_err_q <= PHASE_ERR;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			bucket_q <= BKT_RST >> 1;
		end else if (mode_d != mode_q) begin
			bucket_q <= bkt_sz_q >> 1;
		end else if (bucket_on && pulse_ev && grow && bucket_q != 8'hff) begin
			bucket_q <= bucket_q + 8'h01;
		end else if (bucket_on && pulse_ev && shrink && bucket_q != 8'h00) begin
			bucket_q <= bucket_q - 8'h01;
		end
	end

	// Any out-of-tolerance pulse restarts the soak
	assign soak_ok = pulse_ev && FREQ_P2P <= ftol_q
		&& {1'b0, soak_q} + 17'h1 >= {1'b0, soak_sz_q};
	always_ff @(posedge MCLK) begin
		if (RST || mode_q != M_FREQ) begin
			soak_q <= '0;
		end else if (pulse_ev) begin
			soak_q <= (FREQ_P2P <= ftol_q) ? soak_q + 16'h1 : 16'h0;
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			M_IDLE: begin
				if (started_q && pulse_ev) mode_d = M_FREQ;
			end
			M_FREQ: begin
				if (soak_ok) mode_d = M_FAST;
			end
			M_FAST: begin
				if (drop) mode_d = M_FREQ;
				else if (zero) mode_d = M_LOCKING;
			end
			M_LOCKING: begin
				if (drop) mode_d = M_FREQ;
				else if (bw_q <= tgt_eff) mode_d = M_LOCKED;
			end
			M_LOCKED: begin
				if (drop) mode_d = M_FREQ;
				else if (tgt_eff < bw_q) mode_d = M_LOCKING;
			end
			M_HOLD: begin
				if (!force_ho && pulse_ev)
					mode_d = (PHASE_ERR > reent_q) ? M_FREQ : prior_q;
			end
			default: mode_d = M_IDLE;
		endcase
		if (kick) begin
			mode_d = M_FREQ;
		end else if (started_q && mode_q != M_HOLD && (force_ho || absent)) begin
			if (locked_once_q) mode_d = M_HOLD;
			else if (absent) mode_d = M_IDLE;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			mode_q <= M_IDLE;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			prior_q       <= M_FREQ;
			locked_once_q <= 1'b0;
		end else begin
			if (mode_d == M_HOLD && mode_q != M_HOLD) prior_q <= mode_q;
			if (mode_d == M_LOCKED) locked_once_q <= 1'b1;
		end
	end

	// Bandwidth per mode, with non-linear migration while locking
	always_ff @(posedge MCLK) begin
		if (RST) begin
			bw_q <= FAST_BW_MAX;
		end else if (mode_d != mode_q && (mode_d == M_FREQ || mode_d == M_FAST)) begin
			bw_q <= fast_eff;
		end else if (mode_d != mode_q && mode_d == M_LOCKED) begin
			bw_q <= tgt_eff;
		end else if (mode_q == M_LOCKING && pulse_ev && bw_q > tgt_eff) begin
			bw_q <= bw_q - bw_step(bw_q - tgt_eff, cfg_q[CFG_SPD +: 2]);
		end
	end
	assign BW_INDEX  = bw_q;
	assign LOOP_MODE = mode_q;

	// A new event wins over a clear in the same cycle
	always_comb begin
		intr_clr = '0;
		if (WR && ADDR == A_INTR) intr_clr[7:0] = WDATA;
		if (WR && ADDR == A_INTR + 8'h01) intr_clr[15:8] = WDATA;
		intr_d = (intr_q & ~intr_clr) | {15'h0, mode_d != mode_q};
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			intr_q              <= '0;
			EVENT_INTERRUPT_PIN <= 1'b0;
		end else begin
			intr_q              <= intr_d;
			EVENT_INTERRUPT_PIN <= |intr_d;
		end
	end

	// Calibration taken at the pulse edge, inside the host hold window
	always_ff @(posedge MCLK) begin
		if (RST) begin
			PD_CAL <= '0;
		end else if (pulse_ev) begin
			PD_CAL <= pdcal_q;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			MCLK_TRIM   <= '0;
			HOLDOVER    <= 1'b0;
			ALIGN_X     <= 1'b0;
			ALIGN_Y     <= 1'b0;
			BUILDOUT_PS <= '0;
		end else begin
			if ($signed(trim_q) > TRIM_LIMIT) MCLK_TRIM <= TRIM_LIMIT;
			else if ($signed(trim_q) < -TRIM_LIMIT) MCLK_TRIM <= -TRIM_LIMIT;
			else MCLK_TRIM <= trim_q;
			HOLDOVER    <= mode_d == M_HOLD;
			ALIGN_X     <= started_q && align_valid && cfg_q[CFG_AX];
			ALIGN_Y     <= started_q && align_valid && cfg_q[CFG_AY];
			BUILDOUT_PS <= 16'(rate_q * RATE_STEP_PS) << (rtctl_q[WIDE_BIT] ? WIDE_SHIFT : 0);
		end
	end

	// Output pulse; realigned to the reference only when alignment is valid
	assign wcyc  = 32'(pwid_q) * US_CYCLES;
	assign sec_d = ((pulse_ev && started_q && align_valid) || sec_q >= SEC_CYCLES - 1)
		? 32'h0 : sec_q + 32'h1;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			sec_q   <= '0;
			PPS_OUT <= 1'b0;
		end else begin
			sec_q   <= sec_d;
			PPS_OUT <= sec_d < wcyc;
		end
	end

	assign o11_cfg = '{stage: o11s_q, post: o11p_q, align: started_q && align_valid};
	psm_out11 u_out11 (
		.clk   (MCLK),
		.rst   (RST),
		.cfg   (o11_cfg),
		.align (pulse_ev),
		.out11 (OUT11)
	);

	always_comb begin
		rd_val = 8'h00;
		if (hit(ADDR, A_INTR, 8'h02)) rd_val = rbyte(48'(intr_q), 3'(ADDR - A_INTR));
		else if (ADDR == A_START) rd_val = {7'h0, started_q};
		else if (ADDR == A_RTCTL) rd_val = rtctl_q;
		else if (ADDR == A_CFG) rd_val = cfg_q;
		else if (hit(ADDR, A_AFREQ, 8'h06)) rd_val = rbyte(afreq_q, 3'(ADDR - A_AFREQ));
		else if (ADDR == A_RATE) rd_val = rate_q;
		else if (hit(ADDR, A_PWID, 8'h02)) rd_val = rbyte(48'(pwid_q), 3'(ADDR - A_PWID));
		else if (hit(ADDR, A_O11S, 8'h02)) rd_val = rbyte(48'(o11s_q), 3'(ADDR - A_O11S));
		else if (hit(ADDR, A_O11P, 8'h02)) rd_val = rbyte(48'(o11p_q), 3'(ADDR - A_O11P));
		else if (ADDR == A_MODE) rd_val = {5'h0, mode_q};
		else if (ADDR == A_BWIDX) rd_val = bw_q;
		else if (ADDR == A_TGT) rd_val = tgt_q;
		else if (ADDR == A_FAST) rd_val = fast_q;
		else if (hit(ADDR, A_LOLT, 8'h02)) rd_val = rbyte(48'(lolt_q), 3'(ADDR - A_LOLT));
		else if (hit(ADDR, A_REENT, 8'h02)) rd_val = rbyte(48'(reent_q), 3'(ADDR - A_REENT));
		else if (ADDR == A_BKT) rd_val = bkt_sz_q;
		else if (hit(ADDR, A_SOAK, 8'h02)) rd_val = rbyte(48'(soak_sz_q), 3'(ADDR - A_SOAK));
		else if (hit(ADDR, A_FTOL, 8'h02)) rd_val = rbyte(48'(ftol_q), 3'(ADDR - A_FTOL));
		else if (hit(ADDR, A_PDCAL, 8'h02)) rd_val = rbyte(48'(pdcal_q), 3'(ADDR - A_PDCAL));
		else if (hit(ADDR, A_TRIM, 8'h04)) rd_val = rbyte(48'(trim_q), 3'(ADDR - A_TRIM));
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= RD ? rd_val : 8'h00;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	property p_pin_follows;
		intr_q != 16'h0 |-> EVENT_INTERRUPT_PIN ##1 (intr_q == 16'h0) || EVENT_INTERRUPT_PIN;
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("pin low with status set");

	property p_mode_sets;
		mode_q != $past(mode_q) |-> intr_q[0];
	endproperty
	a_mode_sets: assert property (p_mode_sets) else $error("mode change not flagged");

	property p_w1c;
		WR && ADDR == A_INTR && WDATA[0] && mode_d == mode_q |=> !intr_q[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit not cleared");

	property p_fast_cap;
		mode_q == M_FAST |-> bw_q <= FAST_BW_MAX;
	endproperty
	a_fast_cap: assert property (p_fast_cap) else $error("fast bandwidth above cap");

	property p_demote;
		mode_q == M_LOCKED && bw_q > tgt_eff && !drop && !force_ho && !absent
			|=> mode_q == M_LOCKING;
	endproperty
	a_demote: assert property (p_demote) else $error("no demotion on lower target");

	property p_hold_after_lock;
		mode_q == M_HOLD |-> locked_once_q;
	endproperty
	a_hold_after_lock: assert property (p_hold_after_lock) else $error("early holdover");

	property p_overflow;
		ovf |=> mode_q != M_FAST && mode_q != M_LOCKED;
	endproperty
	a_overflow: assert property (p_overflow) else $error("bucket overflow ignored");

	property p_frozen;
		started_q && WR && ADDR == A_CFG |=> $stable(cfg_q);
	endproperty
	a_frozen: assert property (p_frozen) else $error("set-up changed after start");

	property p_soak_reset;
		mode_q == M_FREQ && pulse_ev && FREQ_P2P > ftol_q && mode_d == M_FREQ |=> soak_q == 16'h0;
	endproperty
	a_soak_reset: assert property (p_soak_reset) else $error("soak not restarted");

	property p_align_valid;
		ALIGN_X || ALIGN_Y |-> $past(align_valid) && $past(started_q);
	endproperty
	a_align_valid: assert property (p_align_valid) else $error("bad alignment setup");
endmodule

// >>> rtl/psm_pkg.sv
package psm_pkg;

	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned US_CYCLES      = CLK_HZ / 1_000_000;
	localparam int unsigned LOS_TIMEOUT_MS = 1500;
	localparam int unsigned LOS_CYCLES_DEF = CLK_HZ / 1000 * LOS_TIMEOUT_MS;
	localparam int unsigned O11_TICK_HZ    = 16_000;

	localparam logic [7:0] A_INTR  = 8'h07;
	localparam logic [7:0] A_START = 8'h35;
	localparam logic [7:0] A_RTCTL = 8'h36;
	localparam logic [7:0] A_CFG   = 8'h45;
	localparam logic [7:0] A_AFREQ = 8'h46;
	localparam logic [7:0] A_RATE  = 8'h4c;
	localparam logic [7:0] A_PWID  = 8'ha0;
	localparam logic [7:0] A_O11S  = 8'ha7;
	localparam logic [7:0] A_O11P  = 8'ha9;
	localparam logic [7:0] A_MODE  = 8'hb0;
	localparam logic [7:0] A_BWIDX = 8'hb1;
	localparam logic [7:0] A_TGT   = 8'hb2;
	localparam logic [7:0] A_FAST  = 8'hb3;
	localparam logic [7:0] A_LOLT  = 8'hb4;
	localparam logic [7:0] A_REENT = 8'hb6;
	localparam logic [7:0] A_BKT   = 8'hb8;
	localparam logic [7:0] A_SOAK  = 8'hb9;
	localparam logic [7:0] A_FTOL  = 8'hbb;
	localparam logic [7:0] A_PDCAL = 8'hbd;
	localparam logic [7:0] A_TRIM  = 8'hc0;

	localparam int unsigned START_BIT = 0;
	localparam int unsigned FORCE_BIT = 0;
	localparam int unsigned WIDE_BIT  = 1;
	localparam int unsigned CFG_AX    = 0;
	localparam int unsigned CFG_AY    = 1;
	localparam int unsigned CFG_SPD   = 2;
	localparam int unsigned AF_BITS   = 17;

	localparam logic [11:0] PWID_RST  = 12'h00a;
	localparam logic [7:0]  CFG_RST   = 8'h00;
	localparam logic [7:0]  RATE_RST  = 8'h01;
	localparam logic [7:0]  RT_RST    = 8'h00;
	localparam logic [7:0]  BKT_RST   = 8'h10;
	localparam logic [15:0] SOAK_RST  = 16'h000a;
	localparam logic [7:0]  FAST_RST  = 8'hc8;
	localparam logic [7:0]  TGT_RST   = 8'h02;
	localparam logic [15:0] LOLT_RST  = 16'h03e8;
	localparam logic [15:0] REENT_RST = 16'h0064;
	localparam logic [15:0] FTOL_RST  = 16'h0064;
	localparam logic [15:0] O11S_RST  = 16'h04e2;
	localparam logic [15:0] O11P_RST  = 16'h0001;

	// Bandwidth index unit is 0.5 mHz
	localparam logic [7:0]  FAST_BW_MAX = 8'hc8;
	// Trim unit is 0.5 ppt
	localparam logic signed [31:0] TRIM_LIMIT = 32'sd228_000_000;
	localparam logic [15:0] RATE_STEP_PS = 16'h000a;
	localparam int unsigned WIDE_SHIFT   = 4;
	localparam logic [2:0]  SH_NORMAL    = 3'h3;
	localparam logic [2:0]  SH_SLOWER    = 3'h4;
	localparam logic [2:0]  SH_SLOWEST   = 3'h5;
	localparam logic [2:0]  SH_FASTER    = 3'h2;

	typedef enum logic [2:0] {
		M_IDLE    = 3'h0,
		M_FREQ    = 3'h1,
		M_FAST    = 3'h3,
		M_LOCKING = 3'h2,
		M_LOCKED  = 3'h6,
		M_HOLD    = 3'h7
	} psm_mode_e;

	typedef struct packed {
		logic [15:0] stage;
		logic [15:0] post;
		logic        align;
	} psm_o11_cfg_s;
endpackage

// >>> rtl/psm_out11.sv
`timescale 1ns/100ps
module psm_out11 import psm_pkg::*; (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Divider settings and alignment strobe
	input  wire psm_o11_cfg_s cfg,
	input  wire logic         align,
	// Clock output
	output logic              out11
);
	logic [31:0] acc_q;
	logic [31:0] acc_sum;
	logic [31:0] inc;
	logic [15:0] post_q;
	logic        tick;
	logic        out_q;
	logic        realign;

	assign inc     = 32'(cfg.stage) * O11_TICK_HZ;
	assign acc_sum = acc_q + inc;
	assign tick    = acc_sum >= CLK_HZ;
	assign realign = align && cfg.align;
	assign out11   = out_q;

	// Initial stage ticks twice per period; rates above half the clock stick at half the clock, one tick every cycle
	always_ff @(posedge clk) begin
		if (rst || realign) begin
			acc_q <= '0;
		end else if (tick) begin
			acc_q <= acc_sum - CLK_HZ;
		end else begin
			acc_q <= acc_sum;
		end
	end

	// Divided output runs at stage times 8 kHz divided by post
	always_ff @(posedge clk) begin
		if (rst) begin
			post_q <= '0;
			out_q  <= 1'b0;
		end else if (realign && cfg.post <= 16'h0001) begin
			post_q <= '0;
			out_q  <= 1'b1;
		end else if (tick) begin
			if (post_q + 16'h0001 >= cfg.post) begin
				post_q <= '0;
				out_q  <= ~out_q;
			end else begin
				post_q <= post_q + 16'h0001;
			end
		end
	end
endmodule

// >>> testbench/psm_ref_src.sv
`timescale 1ns/100ps
module psm_ref_src #(
	parameter int unsigned PER = 400
) (
	// Clock and control
	input  wire logic        clk,
	input  wire logic        en,
	input  wire logic        ld,
	input  wire logic        up,
	input  wire logic [15:0] ld_err,
	// Pulse and detector values
	output logic             pps,
	output logic      [15:0] err,
	output logic      [15:0] p2p
);
	int unsigned cnt = 0;
	int unsigned np  = 0;
	initial begin
		pps = 1'b0;
		err = 16'h0000;
		p2p = 16'h000a;
	end
	// Error falls one per pulse so the bucket drains; up makes it grow
	// Second pulse after enable breaks the frequency tolerance once
	always @(posedge clk) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		pps <= en && (cnt < 20);
		np  <= !en ? 0 : (cnt == 0 && np < 3) ? np + 1 : np;
		p2p <= (np == 2) ? 16'h00ff : 16'h000a;
		if (ld)
			err <= ld_err;
		else if (en && cnt == 0 && up)
			err <= err + 16'h0001;
		else if (en && cnt == 0 && err != 16'h0000)
			err <= err - 16'h0001;
	end
endmodule

// >>> testbench/pps_sync_mode_control_tb_top.sv
`timescale 1ns/100ps
module pps_sync_mode_control_tb_top import psm_pkg::*;;
	localparam int unsigned SEC = 400;
	logic        mclk   = 1'b0;
	logic        rst    = 1'b1;
	logic [7:0]  addr   = 8'h00;
	logic [7:0]  wdata  = 8'h00;
	logic        wr_s   = 1'b0;
	logic        rd_s   = 1'b0;
	logic        en     = 1'b0;
	logic        ld     = 1'b0;
	logic        up     = 1'b0;
	logic [15:0] ld_err = 16'h0384;
	logic [15:0] err, p2p, pdcal, bo;
	logic [7:0]  rdata, bw;
	logic [31:0] trim;
	logic [2:0]  mode;
	logic        pps, hold, irq, ax, ay, pout, o11;
	int          n_mismatch = 0;
	int          checked    = 0;
	int          cyc        = 0;

	always #12.5 mclk = ~mclk;

	psm_ref_src #(.PER(SEC)) i_psm_ref_src (.clk(mclk), .en(en), .ld(ld), .up(up), .ld_err(ld_err),
		.pps(pps), .err(err), .p2p(p2p));

	psm_ctrl #(.SEC_CYCLES(SEC), .LOS_CYCLES(1000)) i_psm_ctrl (.MCLK(mclk), .RST(rst),
		.ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .REF_PPS(pps),
		.PHASE_ERR(err), .FREQ_P2P(p2p), .LOOP_MODE(mode), .BW_INDEX(bw), .HOLDOVER(hold),
		.EVENT_INTERRUPT_PIN(irq), .PD_CAL(pdcal), .MCLK_TRIM(trim), .ALIGN_X(ax),
		.ALIGN_Y(ay), .BUILDOUT_PS(bo), .PPS_OUT(pout), .OUT11(o11));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask

	// One idle edge before each strobe keeps drivers from colliding
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1;
		chk("rdata", {24'h0, e}, {24'h0, rdata});
	endtask

	task automatic wr32(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(A_TRIM + 8'(i), v[8*i+:8]);
		// Trim output is one flop behind the register
		@(posedge mclk);
		#1;
	endtask

	task automatic load(input logic [15:0] v);
		@(posedge mclk);
		ld_err <= v;
		ld <= 1'b1;
		@(posedge mclk);
		ld <= 1'b0;
	endtask

	task automatic wait_mode(input logic [2:0] m);
		int unsigned n = 0;
		while (mode !== m && n < 30000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("mode", {29'h0, m}, {29'h0, mode});
	endtask

	task automatic pulse_width();
		int unsigned n = 0;
		while (pout !== 1'b0) begin
			@(posedge mclk);
			#1;
		end
		while (pout !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		while (pout === 1'b1 && n < SEC) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("pps_width", 2 * US_CYCLES, n);
	endtask

	// Default stage is 1250 steps of 8 kHz; no realign before start
	task automatic out11_rate();
		int unsigned n = 0;
		logic        prev;
		@(posedge mclk);
		#1;
		prev = o11;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (o11 && !prev) n++;
			prev = o11;
		end
		chk("out11_rises", 40 * 8000 * O11S_RST / CLK_HZ, n);
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			summarize();
		end
	end

	// Fast bandwidth never runs above its ceiling
	always @(posedge mclk) if (!rst && bw > FAST_BW_MAX) begin
		n_mismatch++;
		$display("BAD bw exp <= %h got %h", FAST_BW_MAX, bw);
	end

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(A_INTR, 8'h00);
		rd(A_PWID, 8'h0a);
		rd(A_CFG, 8'h00);
		rd(A_AFREQ, 8'h00);
		rd(A_BWIDX, 8'hc8);
		rd(8'hff, 8'h00);
		out11_rate();
		$display("test reset done");
		wr(A_PWID, 8'h02);
		wr(A_RATE, 8'h03);
		wr(A_CFG, 8'h0d);
		wr(A_AFREQ, 8'h01);
		wr(A_FAST, 8'hff);
		wr32(32'hffffff9c);
		chk("trim", 32'hffffff9c, trim);
		wr32(32'h7fffffff);
		chk("trim_sat", TRIM_LIMIT, trim);
		wr(A_START, 8'h01);
		wr(A_CFG, 8'h00);
		rd(A_CFG, 8'h0d);
		chk("align_x", 1, ax);
		chk("align_y", 0, ay);
		chk("buildout", 30, bo);
		$display("test setup done");
		load(16'h0384);
		en <= 1'b1;
		wait_mode(M_FREQ);
		chk("irq", 1, irq);
		rd(A_INTR, 8'h01);
		wr(A_INTR, 8'h00);
		rd(A_INTR, 8'h01);
		chk("irq_kept", 1, irq);
		wr(A_INTR, 8'h01);
		rd(A_INTR, 8'h00);
		chk("irq_clr", 0, irq);
		wait_mode(M_FAST);
		chk("bw_fast", FAST_BW_MAX, bw);
		wait_mode(M_LOCKED);
		chk("bw_tgt", TGT_RST, bw);
		wr(A_TGT, 8'h01);
		wait_mode(M_LOCKING);
		wait_mode(M_LOCKED);
		rd(A_BWIDX, 8'h01);
		$display("test lock done");
		wr(A_PDCAL, 8'h34);
		wr(A_PDCAL + 8'h01, 8'h12);
		pulse_width();
		// Two periods always hold two pulse events
		repeat (2 * SEC) @(posedge mclk);
		chk("pd_cal", 16'h1234, pdcal);
		wr(A_RTCTL, 8'h03);
		wait_mode(M_HOLD);
		chk("holdover", 1, hold);
		chk("buildout_wide", 30 << WIDE_SHIFT, bo);
		load(16'h0032);
		wr(A_RTCTL, 8'h00);
		wait_mode(M_LOCKED);
		wr(A_RTCTL, 8'h01);
		wait_mode(M_HOLD);
		load(16'h00c8);
		wr(A_RTCTL, 8'h00);
		wait_mode(M_FREQ);
		wait_mode(M_LOCKED);
		wr(A_LOLT, 8'h64);
		wr(A_LOLT + 8'h01, 8'h00);
		load(16'h00c8);
		wait_mode(M_FREQ);
		wr(A_LOLT, 8'he8);
		wr(A_LOLT + 8'h01, 8'h03);
		wait_mode(M_LOCKED);
		up <= 1'b1;
		wait_mode(M_FREQ);
		up <= 1'b0;
		$display("test lock loss done");
		en <= 1'b0;
		wait_mode(M_HOLD);
		load(16'h0384);
		en <= 1'b1;
		wait_mode(M_FREQ);
		$display("test holdover done");
		summarize();
	end
endmodule
